// [rtl/udi_params.svh]
// Offsets, field positions, reset values and timing counts of the block
`ifndef UDI_PARAMS_SVH
`define UDI_PARAMS_SVH
`define UDI_OFF_IRQ_ENABLE 8'h10
`define UDI_OFF_IRQ_DISABLE 8'h14
`define UDI_OFF_IRQ_VIEW 8'h18
`define UDI_OFF_IRQ_PENDING 8'h1c
`define UDI_OFF_IRQ_CLEAR 8'h20
`define UDI_OFF_EP_RESET 8'h28
`define UDI_OFF_CONTROL 8'h2c
`define UDI_BIT_SUSP 8
`define UDI_BIT_RSM 9
`define UDI_BIT_EXT 10
`define UDI_BIT_SOF 11
`define UDI_BIT_BRST 12
`define UDI_BIT_WAKE 13
`define UDI_CTL_ESR 0
`define UDI_CTL_RWU 1
`define UDI_ENABLE_RST 14'h0200
`define UDI_ENABLE_MASK 14'h2fff
`define UDI_CLEAR_MASK 14'h3f00
`define UDI_CLK_HZ 50000000
`define UDI_IDLE_US 3000
`define UDI_IDLE_CYCLES ((`UDI_CLK_HZ / 1000000) * `UDI_IDLE_US)
`endif

// [rtl/udi_pkg.sv]
// Types shared by the interrupt and endpoint reset block
package udi_pkg;
   typedef struct packed
   {
      logic [7:0] setup_received_flag;
      logic [7:0] bank0_received_flag;
      logic [7:0] bank1_received_flag;
      logic [7:0] transmit_done_flag;
      logic [7:0] stall_acknowledged_flag;
   } udi_ep_flags_type;
   typedef struct packed
   {
      logic bus_activity;
      logic host_resume_seen;
      logic frame_start_seen;
      logic bus_reset_done;
      logic resume_request;
   } udi_bus_type;
   typedef enum logic [1:0] {UDI_ACTIVE, UDI_SUSPENDED} udi_state_type;
endpackage

// [rtl/udi_irq_ep_reset.sv]
// Interrupt bookkeeping and endpoint FIFO reset for a USB device port
// Summary of operation
// - Disable register bits 0-7 written one turn off endpoint enables.
// - Disable bits 8-11 and 13 written one turn off event enables.
// - Mask register reads one for each enabled endpoint interrupt.
// - Mask register also shows the bus event enables.
// - Resume interrupt enable is set out of reset.
// - Endpoint status bit is high while any of its five flags is high.
// - Endpoint status clears only via its flags; status is read-only.
// - Three ms of bus idle sets suspend status and enters suspend.
// - Host resume signalling sets the resume status bit.
// - Rising resume request while suspended sets external resume status.
// - External resume drives bus resume when remote wakeup is enabled.
// - Each start-of-frame token sets the frame start status bit.
// - End of bus reset sets its status bit.
// - Host resume or bus reset sets wakeup status until cleared.
// - Clear register bits 8-13 written one clear bus event status.
// - Endpoint reset bit holds its FIFO pointers at zero.
// - Endpoint reset bit returns the data toggle to DATA0.
// - Enable register bits 0-11 and 13 written one set the matching enable.
// - Bus resume is driven only when send-resume enable is also set.
`timescale 1ns/10ps
`include "udi_params.svh"
module udi_irq_ep_reset
   import udi_pkg::*;
#(
   parameter int NUM_EP = 8,
   parameter int IDLE_CYCLES = `UDI_IDLE_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire udi_ep_flags_type ep_flags,
   input wire udi_bus_type bus_in,
   input wire logic [NUM_EP-1:0] toggle_advance,
   output logic [NUM_EP-1:0] ep_fifo_hold,
   output logic [NUM_EP-1:0] data_toggle,
   output logic suspended,
   output logic drive_resume,
   output logic irq
);
   localparam logic [13:0] ENABLE_RST = `UDI_ENABLE_RST;
   localparam logic [13:0] ENABLE_MASK = `UDI_ENABLE_MASK;
   localparam logic [13:0] CLEAR_MASK = `UDI_CLEAR_MASK;
   localparam logic [31:0] IDLE_LAST = 32'(IDLE_CYCLES - 1);

   logic [7:0] aw_addr_r;
   logic aw_full_r;
   logic [31:0] w_data_r;
   logic w_full_r;
   logic wr_go;
   logic [13:0] enable_r;
   logic [13:0] en_set;
   logic [13:0] en_clr;
   logic [13:0] clr_strobe;
   logic [13:8] event_r;
   logic [13:8] event_keep;
   logic [13:0] pending;
   logic [7:0] ep_reset_r;
   logic [1:0] control_r;
   logic [31:0] idle_cnt_r;
   udi_state_type state_r;
   logic req_prev_r;
   logic drive_resume_r;
   logic [NUM_EP-1:0] toggle_r;
   logic idle_hit;
   logic ext_event;
   logic [31:0] rd_val;

   // Write channel capture; address and data taken in either order
   assign s_axi_awready = !aw_full_r;
   assign s_axi_wready = !w_full_r;
   assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         aw_full_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end
      else if (s_axi_awvalid && !aw_full_r)
      begin
         aw_full_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_go)
         aw_full_r <= 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         w_full_r <= 1'b0;
         w_data_r <= 32'h00000000;
      end
      else if (s_axi_wvalid && !w_full_r)
      begin
         w_full_r <= 1'b1;
         w_data_r <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      else if (wr_go)
         w_full_r <= 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         case (aw_addr_r)
            `UDI_OFF_IRQ_ENABLE, `UDI_OFF_IRQ_DISABLE, `UDI_OFF_IRQ_CLEAR,
            `UDI_OFF_EP_RESET, `UDI_OFF_CONTROL: s_axi_bresp <= 2'h0;
            `UDI_OFF_IRQ_VIEW, `UDI_OFF_IRQ_PENDING: s_axi_bresp <= 2'h2;
            default: s_axi_bresp <= 2'h2;
         endcase
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Write strobes decoded from the committed write
   always_comb
   begin
      en_set = 14'h0000;
      en_clr = 14'h0000;
      clr_strobe = 14'h0000;
      if (wr_go)
      begin
         case (aw_addr_r)
            `UDI_OFF_IRQ_ENABLE:
               en_set = w_data_r[13:0] & ENABLE_MASK;
            `UDI_OFF_IRQ_DISABLE:
               en_clr = w_data_r[13:0] & ENABLE_MASK;
            `UDI_OFF_IRQ_CLEAR:
               clr_strobe = w_data_r[13:0] & CLEAR_MASK;
            default: en_set = 14'h0000;
         endcase
      end
   end

   // Enable bits; disable wins over enable
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         enable_r <= ENABLE_RST;
      else
         enable_r <= (enable_r | en_set) & ~en_clr;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ep_reset_r <= 8'h00;
         control_r <= 2'h0;
      end
      else if (wr_go && aw_addr_r == `UDI_OFF_EP_RESET)
         ep_reset_r <= w_data_r[7:0];
      else if (wr_go && aw_addr_r == `UDI_OFF_CONTROL)
         control_r <= w_data_r[1:0];
   end

   // Suspend detection from bus idle time
   assign idle_hit = idle_cnt_r == IDLE_LAST;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         idle_cnt_r <= 32'h00000000;
      else if (bus_in.bus_activity || state_r == UDI_SUSPENDED)
         idle_cnt_r <= 32'h00000000;
      else if (!idle_hit)
         idle_cnt_r <= idle_cnt_r + 32'h00000001;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         state_r <= UDI_ACTIVE;
      else
      begin
         case (state_r)
            UDI_ACTIVE:
               if (idle_hit && !bus_in.bus_activity)
                  state_r <= UDI_SUSPENDED;
            UDI_SUSPENDED:
               if (bus_in.bus_activity || bus_in.host_resume_seen)
                  state_r <= UDI_ACTIVE;
            default: state_r <= UDI_ACTIVE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         req_prev_r <= 1'b0;
      else
         req_prev_r <= bus_in.resume_request;
   end

   assign ext_event = bus_in.resume_request && !req_prev_r
      && state_r == UDI_SUSPENDED;

   // Remote wakeup drive, held until bus activity returns or the state leaves suspend
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         drive_resume_r <= 1'b0;
      else if (ext_event && control_r[`UDI_CTL_RWU]
         && control_r[`UDI_CTL_ESR])
         drive_resume_r <= 1'b1;
      else if (bus_in.bus_activity || state_r == UDI_ACTIVE)
         drive_resume_r <= 1'b0;
   end

   // Sticky bus event status; a set wins over a clear
   assign event_keep = event_r & ~clr_strobe[13:8];
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         event_r <= 6'h00;
      else
      begin
         event_r[`UDI_BIT_SUSP] <= (state_r == UDI_ACTIVE && idle_hit
            && !bus_in.bus_activity) || event_keep[`UDI_BIT_SUSP];
         event_r[`UDI_BIT_RSM] <= bus_in.host_resume_seen
            || event_keep[`UDI_BIT_RSM];
         event_r[`UDI_BIT_EXT] <= ext_event
            || event_keep[`UDI_BIT_EXT];
         event_r[`UDI_BIT_SOF] <= bus_in.frame_start_seen
            || event_keep[`UDI_BIT_SOF];
         event_r[`UDI_BIT_BRST] <= bus_in.bus_reset_done
            || event_keep[`UDI_BIT_BRST];
         event_r[`UDI_BIT_WAKE] <= bus_in.host_resume_seen
            || bus_in.bus_reset_done || event_keep[`UDI_BIT_WAKE];
      end
   end

   // Endpoint status follows the endpoint flags, fifo hold and toggle
   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++)
      begin : g_ep
         assign pending[g] = ep_flags.setup_received_flag[g]
            | ep_flags.bank0_received_flag[g]
            | ep_flags.bank1_received_flag[g]
            | ep_flags.transmit_done_flag[g]
            | ep_flags.stall_acknowledged_flag[g];
         assign ep_fifo_hold[g] = ep_reset_r[g];

         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
               toggle_r[g] <= 1'b0;
            else if (ep_reset_r[g])
               toggle_r[g] <= 1'b0;
            else if (toggle_advance[g])
               toggle_r[g] <= !toggle_r[g];
         end
      end
   endgenerate

   assign pending[13:8] = event_r;
   assign data_toggle = toggle_r;
   assign suspended = state_r == UDI_SUSPENDED;
   assign drive_resume = drive_resume_r;
   assign irq = |(pending & enable_r);

   // Read channel
   always_comb
   begin
      case (s_axi_araddr)
         `UDI_OFF_IRQ_VIEW: rd_val = {18'h0, enable_r};
         `UDI_OFF_IRQ_PENDING: rd_val = {18'h0, pending};
         `UDI_OFF_EP_RESET: rd_val = {24'h000000, ep_reset_r};
         `UDI_OFF_CONTROL: rd_val = {30'h0, control_r};
         default: rd_val = 32'h00000000;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         case (s_axi_araddr)
            `UDI_OFF_IRQ_VIEW, `UDI_OFF_IRQ_PENDING, `UDI_OFF_EP_RESET,
            `UDI_OFF_CONTROL: s_axi_rresp <= 2'h0;
            default: s_axi_rresp <= 2'h2;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Checks
   property p_resume_en_reset;
      @(posedge ref_clk) $fell(rst) |-> enable_r[`UDI_BIT_RSM];
   endproperty
   a_resume_en_reset: assert property (p_resume_en_reset)
      else $error("resume enable not set after reset");
   property p_disable_wins;
      @(posedge ref_clk) disable iff (rst)
      (en_clr != 14'h0000) |=> ((enable_r & $past(en_clr)) == 14'h0000);
   endproperty
   a_disable_wins: assert property (p_disable_wins)
      else $error("disable strobe left enable set");
   property p_enable_set;
      @(posedge ref_clk) disable iff (rst)
      (en_set != 14'h0000 && en_clr == 14'h0000)
      |=> ((enable_r & $past(en_set)) == $past(en_set));
   endproperty
   a_enable_set: assert property (p_enable_set)
      else $error("enable strobe did not set enable");
   property p_irq_out;
      @(posedge ref_clk) disable iff (rst)
      irq == (|(pending & enable_r));
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("irq does not match enabled status");
   property p_suspend_time;
      @(posedge ref_clk) disable iff (rst)
      (state_r == UDI_ACTIVE && idle_hit && !bus_in.bus_activity)
      |=> (suspended && event_r[`UDI_BIT_SUSP]);
   endproperty
   a_suspend_time: assert property (p_suspend_time)
      else $error("suspend not entered after idle");
   property p_wake_set;
      @(posedge ref_clk) disable iff (rst)
      (bus_in.host_resume_seen || bus_in.bus_reset_done)
      |=> event_r[`UDI_BIT_WAKE];
   endproperty
   a_wake_set: assert property (p_wake_set)
      else $error("wakeup status not set");
   property p_clear_event;
      @(posedge ref_clk) disable iff (rst)
      (clr_strobe[`UDI_BIT_SOF] && !bus_in.frame_start_seen)
      |=> !event_r[`UDI_BIT_SOF];
   endproperty
   a_clear_event: assert property (p_clear_event)
      else $error("frame start status not cleared");
   property p_toggle_reset;
      @(posedge ref_clk) disable iff (rst)
      (ep_reset_r[0]) |=> (data_toggle[0] == 1'b0);
   endproperty
   a_toggle_reset: assert property (p_toggle_reset)
      else $error("toggle not returned to DATA0");
   property p_remote_gate;
      @(posedge ref_clk) disable iff (rst)
      $rose(drive_resume) |-> $past(control_r) == 2'h3 && $past(ext_event);
   endproperty
   a_remote_gate: assert property (p_remote_gate)
      else $error("resume driven without enables");
   c_suspend: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(suspended));
   c_ext: cover property (@(posedge ref_clk) disable iff (rst) ext_event);
   c_irq: cover property (@(posedge ref_clk) disable iff (rst) $rose(irq));
   c_drive: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(drive_resume));
endmodule

// [verif/udi_host_model.sv]
// Host side model driving bus events and the resume request
`timescale 1ns/10ps
module udi_host_model
   import udi_pkg::*;
(
   input wire logic ref_clk,
   output udi_bus_type bus_out
);
   initial bus_out = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
   // One cycle event: 1 host resume, 2 frame start, 3 reset done
   task pulse(input int e);
      @(posedge ref_clk);
      bus_out.host_resume_seen <= (e == 1);
      bus_out.frame_start_seen <= (e == 2);
      bus_out.bus_reset_done <= (e == 3);
      @(posedge ref_clk);
      bus_out.host_resume_seen <= 1'b0;
      bus_out.frame_start_seen <= 1'b0;
      bus_out.bus_reset_done <= 1'b0;
   endtask
   // Bus traffic level; low lets the device see an idle bus
   task traffic(input logic v);
      @(posedge ref_clk);
      bus_out.bus_activity <= v;
   endtask
   task req(input logic v);
      @(posedge ref_clk);
      bus_out.resume_request <= v;
   endtask
endmodule

// [verif/tb.sv]
// Register level testbench of the interrupt and endpoint reset block
`timescale 1ns/10ps
module tb;
   import udi_pkg::*;
   localparam int IDLE = 20;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, susp, drv, irq;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rv;
   logic [7:0] tadv = 8'h00;
   logic [3:0] wstrb = 4'hf;
   logic [7:0] hold, tog;
   udi_ep_flags_type ep_flags = '0;
   udi_bus_type bus;
   int err_total = 0;
   int n_compared = 0;
   int n;
   localparam logic [31:0] EV_EXP [1:3] = '{32'h2200, 32'h0800, 32'h3000};

   always #10 ref_clk = ~ref_clk;

   udi_host_model i_udi_host_model (.ref_clk(ref_clk), .bus_out(bus));

   udi_irq_ep_reset #(.IDLE_CYCLES(IDLE)) i_udi_irq_ep_reset (
      .ref_clk(ref_clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ep_flags(ep_flags),
      .bus_in(bus), .toggle_advance(tadv), .ep_fifo_hold(hold),
      .data_toggle(tog), .suspended(susp), .drive_resume(drv), .irq(irq));

   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", s, e, g);
         err_total++;
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         if (awvalid && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid && wready === 1'b1)
            wvalid <= 1'b0;
         n++;
      end
      while (bvalid !== 1'b1 && n < 50);
      rs = bresp;
      bready <= 1'b0;
      chk("write answer", 32'h1, 32'(n < 50));
   endtask

   task rd(input logic [7:0] a);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         if (arvalid && arready === 1'b1)
            arvalid <= 1'b0;
         n++;
      end
      while (rvalid !== 1'b1 && n < 50);
      rv = rdata;
      rs = rresp;
      rready <= 1'b0;
      chk("read answer", 32'h1, 32'(n < 50));
   endtask

   task see(input logic [7:0] a, input logic [31:0] e, input string s);
      rd(a);
      chk(s, e, rv);
   endtask

   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #400000;
      err_total++;
      end_of_test();
   end

   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      see(8'h18, 32'h0200, "mask");
      see(8'h1c, 32'h0, "pending");
      chk("irq", 32'h0, {31'h0, irq});
      $display("test reset done");
      wr(8'h10, 32'hffff_ffff);
      see(8'h18, 32'h2fff, "mask");
      wr(8'h14, 32'h8);
      see(8'h18, 32'h2ff7, "mask");
      wr(8'h14, 32'h2f00);
      see(8'h18, 32'h00f7, "mask");
      wr(8'h14, 32'h0);
      see(8'h18, 32'h00f7, "mask");
      $display("test enables done");
      for (int f = 0; f < 5; f++)
      begin
         ep_flags <= udi_ep_flags_type'(40'h1 << (9 * f + 1));
         repeat (2) @(posedge ref_clk);
         see(8'h1c, 32'h1 << (f + 1), "pending");
         chk("irq", 32'(f != 2), {31'h0, irq});
         wr(8'h1c, 32'h0);
         chk("bresp", 32'h2, {30'h0, rs});
         see(8'h1c, 32'h1 << (f + 1), "pending");
         ep_flags <= '0;
         repeat (2) @(posedge ref_clk);
         see(8'h1c, 32'h0, "pending");
      end
      $display("test endpoint status done");
      wr(8'h10, 32'h0800);
      for (int e = 1; e < 4; e++)
      begin
         i_udi_host_model.pulse(e);
         repeat (2) @(posedge ref_clk);
         see(8'h1c, EV_EXP[e], "event");
         chk("irq", 32'(e == 2), {31'h0, irq});
         wr(8'h20, 32'h0200);
         see(8'h1c, EV_EXP[e] & ~32'h0200, "pending");
         wr(8'h20, 32'h3d00);
         see(8'h1c, 32'h0, "pending");
      end
      $display("test bus events done");
      i_udi_host_model.traffic(1'b0);
      repeat (IDLE + 5) @(posedge ref_clk);
      chk("suspended", 32'h1, {31'h0, susp});
      see(8'h1c, 32'h0100, "pending");
      wr(8'h2c, 32'h3);
      i_udi_host_model.req(1'b1);
      repeat (3) @(posedge ref_clk);
      chk("drive resume", 32'h1, {31'h0, drv});
      see(8'h1c, 32'h0500, "pending");
      i_udi_host_model.req(1'b0);
      i_udi_host_model.traffic(1'b1);
      repeat (2) @(posedge ref_clk);
      chk("suspended", 32'h0, {31'h0, susp});
      wr(8'h20, 32'h3f00);
      wr(8'h2c, 32'h2);
      i_udi_host_model.traffic(1'b0);
      repeat (IDLE + 5) @(posedge ref_clk);
      i_udi_host_model.req(1'b1);
      repeat (3) @(posedge ref_clk);
      chk("drive resume", 32'h0, {31'h0, drv});
      i_udi_host_model.req(1'b0);
      i_udi_host_model.traffic(1'b1);
      wr(8'h20, 32'h3f00);
      $display("test suspend done");
      tadv <= 8'hff;
      @(posedge ref_clk);
      tadv <= 8'h00;
      ep_flags <= udi_ep_flags_type'(40'hff);
      repeat (2) @(posedge ref_clk);
      chk("toggle", 32'hff, {24'h0, tog});
      wr(8'h28, 32'h81);
      @(negedge ref_clk);
      chk("fifo hold", 32'h81, {24'h0, hold});
      chk("toggle", 32'h7e, {24'h0, tog});
      see(8'h28, 32'h81, "endpoint reset");
      see(8'h1c, 32'hff, "pending");
      wr(8'h28, 32'h0);
      chk("fifo hold", 32'h0, {24'h0, hold});
      wstrb <= 4'h2;
      wr(8'h14, 32'h0000ffff);
      wstrb <= 4'hf;
      see(8'h18, 32'h00f7, "strobed mask");
      rd(8'h04);
      chk("rresp", 32'h2, {30'h0, rs});
      chk("rdata", 32'h0, rv);
      $display("test endpoint reset done");
      end_of_test();
   end
endmodule
